// >>> include/brsse_pkg.sv
`default_nettype none
package brsse_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam int          APB_ADDR_W   = 12;
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_ACCUM    = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_BANK     = 12'h00c;
  localparam logic [11:0] OFS_INDEX    = 12'h010;
  localparam logic [11:0] OFS_INSTR    = 12'h014;
  localparam logic [11:0] OFS_MEM_ADDR = 12'h018;
  localparam logic [11:0] OFS_MEM_DATA = 12'h01c;
  localparam logic [11:0] OFS_INFO     = 12'h020;

  // ==========================================================================
  // Reset values
  localparam logic        RST_CTRL     = 1'b0;
  localparam logic [7:0]  RST_ACCUM    = 8'h00;
  localparam logic [4:0]  RST_STATUS   = 5'h00;
  localparam logic [3:0]  RST_BANK     = 4'h0;
  localparam logic [11:0] RST_INDEX    = 12'h000;
  localparam logic [11:0] RST_MEM_ADDR = 12'h000;
  localparam logic [15:0] RST_INSTR    = 16'h0000;
  localparam logic [7:0]  RST_FILE     = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int FLAG_C       = 0;
  localparam int FLAG_HALF_CARRY   = 1;
  localparam int FLAG_Z            = 2;
  localparam int FLAG_SIGNED_RANGE = 3;
  localparam int FLAG_N       = 4;
  localparam int STATUS_W     = 5;
  localparam int BIT_DEST     = 9;
  localparam int BIT_BANK     = 8;
  localparam int INFO_RES_LSB = 12;

  // ==========================================================================
  // Opcode patterns and addressing constants
  localparam logic [5:0] OPC_ROTATE   = 6'h10;
  localparam logic [6:0] OPC_SET      = 7'h34;
  localparam logic [7:0] OPC_SUB_LIT  = 8'h08;
  localparam logic [5:0] OPC_SUB_FILE = 6'h17;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEXED_MAX  = 8'h5f;
  localparam logic [3:0] ACCESS_LO    = 4'h0;
  localparam logic [3:0] ACCESS_HI    = 4'hf;
  localparam logic [7:0] ALL_ONES     = 8'hff;
  localparam int         DATA_ADDR_W  = 12;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    op_none,
    rotate_right_no_carry_op,
    set_all_ones_op,
    literal_minus_accumulator_op,
    register_minus_accumulator_op
  } brsse_op_t;

  typedef enum logic [2:0] {
    st_idle,
    st_decode,
    st_read,
    st_process,
    st_write
  } brsse_state_t;

  typedef struct packed {
    brsse_op_t  op;
    logic       dest_file;
    logic       bank_bit;
    logic [7:0] faddr;
  } brsse_dec_t;

  typedef struct packed {
    logic                   en;
    logic [DATA_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } brsse_wr_t;

endpackage : brsse_pkg
`default_nettype wire

// >>> rtl/brsse_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Rotate right without carry: bit zero to bit seven, only N and Z change.
// RULE_02: Destination bit 0 writes the accumulator, 1 writes back the addressed register.
// RULE_03: Bank bit 0 uses the fixed access bank, 1 uses the bank select register.
// RULE_04: Extended set, bank bit 0 and address up to 95: indexed literal-offset address.
// RULE_05: One word per instruction; four phases: decode, read, process, write.
// RULE_06: Set instruction loads all ones into the register, no flag changes.
// RULE_07: Literal minus accumulator into accumulator, updating all five subtraction flags.
// RULE_08: Subtraction carry set when no borrow; zero flag only on zero result.
// RULE_09: Register minus accumulator, routed by destination bit, updating five flags.
// RULE_10: Half carry on no low-nibble borrow; overflow on signed range violation.
module brsse_exec #(
  parameter int FILE_DEPTH_W = 12
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [brsse_pkg::APB_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr
);

  brsse_pkg::brsse_state_t state;
  brsse_pkg::brsse_dec_t   dec;
  brsse_pkg::brsse_wr_t    file_wr;

  logic                                    ext_enable;
  logic [7:0]                              accum;
  logic [brsse_pkg::STATUS_W-1:0]          status;
  logic [3:0]                              bank_select_register;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       index_base;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       mem_addr;
  logic [15:0]                             work_word;
  logic [15:0]                             last_instr;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       eff_addr;
  logic [7:0]                              operand;
  logic [7:0]                              result;
  logic [brsse_pkg::STATUS_W-1:0]          flags;
  logic [7:0]                              last_result;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       last_addr;
  logic [7:0]                              file_rd_data;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       file_rd_addr;
  logic [7:0]                              next_result;
  logic [brsse_pkg::STATUS_W-1:0]          next_flags;
  logic [8:0]                              diff;
  logic [4:0]                              diff_low;
  logic [brsse_pkg::DATA_ADDR_W-1:0]       next_eff_addr;
  brsse_pkg::brsse_dec_t                   next_dec;
  brsse_pkg::brsse_dec_t                   pw_dec;
  logic                                    setup;
  logic                                    wr_done;
  logic                                    instr_hit;
  logic                                    instr_ok;

  // ==========================================================================
  // Decoding helpers
  function automatic brsse_pkg::brsse_dec_t decode(input logic [15:0] w);
    brsse_pkg::brsse_dec_t d;
    d.op        = brsse_pkg::op_none;
    d.dest_file = w[brsse_pkg::BIT_DEST];
    d.bank_bit  = w[brsse_pkg::BIT_BANK];
    d.faddr     = w[7:0];
    if (w[15:10] == brsse_pkg::OPC_ROTATE) begin
      d.op = brsse_pkg::rotate_right_no_carry_op; // RULE_01
    end else if (w[15:9] == brsse_pkg::OPC_SET) begin
      d.op        = brsse_pkg::set_all_ones_op;
      d.dest_file = 1'b1; // RULE_06
    end else if (w[15:8] == brsse_pkg::OPC_SUB_LIT) begin
      d.op        = brsse_pkg::literal_minus_accumulator_op;
      d.dest_file = 1'b0; // RULE_07
    end else if (w[15:10] == brsse_pkg::OPC_SUB_FILE) begin
      d.op = brsse_pkg::register_minus_accumulator_op; // RULE_09
    end
    return d;
  endfunction : decode

  function automatic logic addr_known(input logic [brsse_pkg::APB_ADDR_W-1:0] a);
    return (a == brsse_pkg::OFS_CTRL)     || (a == brsse_pkg::OFS_ACCUM) ||
           (a == brsse_pkg::OFS_STATUS)   || (a == brsse_pkg::OFS_BANK) ||
           (a == brsse_pkg::OFS_INDEX)    || (a == brsse_pkg::OFS_INSTR) ||
           (a == brsse_pkg::OFS_MEM_ADDR) || (a == brsse_pkg::OFS_MEM_DATA) ||
           (a == brsse_pkg::OFS_INFO);
  endfunction : addr_known

  assign setup     = psel && !penable;
  assign wr_done   = psel && penable && pready && pwrite;
  assign instr_hit = setup && pwrite && (paddr == brsse_pkg::OFS_INSTR);
  assign pw_dec    = decode(pwdata[15:0]);
  assign instr_ok  = pw_dec.op != brsse_pkg::op_none;

  // ==========================================================================
  // Four-phase execution sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= brsse_pkg::st_idle;
    end else begin
      case (state) // RULE_05
        brsse_pkg::st_idle: begin
          if (instr_hit && instr_ok) begin
            state <= brsse_pkg::st_decode;
          end
        end
        brsse_pkg::st_decode:  state <= brsse_pkg::st_read;
        brsse_pkg::st_read:    state <= brsse_pkg::st_process;
        brsse_pkg::st_process: state <= brsse_pkg::st_write;
        default:               state <= brsse_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_word <= brsse_pkg::RST_INSTR;
    end else if (instr_hit && instr_ok && (state == brsse_pkg::st_idle)) begin
      work_word <= pwdata[15:0];
    end
  end

  // ==========================================================================
  // Decode phase: operand address
  always_comb begin
    next_dec = decode(work_word);
    if (!next_dec.bank_bit && ext_enable && (next_dec.faddr <= brsse_pkg::INDEXED_MAX)) begin
      next_eff_addr = index_base + {4'h0, next_dec.faddr}; // RULE_04
    end else if (!next_dec.bank_bit) begin
      next_eff_addr = (next_dec.faddr < brsse_pkg::ACCESS_SPLIT) ?
                      {brsse_pkg::ACCESS_LO, next_dec.faddr} :
                      {brsse_pkg::ACCESS_HI, next_dec.faddr}; // RULE_03
    end else begin
      next_eff_addr = {bank_select_register, next_dec.faddr}; // RULE_03
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec      <= '0;
      eff_addr <= '0;
    end else if (state == brsse_pkg::st_decode) begin
      dec      <= next_dec;
      eff_addr <= next_eff_addr;
    end
  end

  // ==========================================================================
  // Read phase: literal or file operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= 8'h00;
    end else if (state == brsse_pkg::st_read) begin
      if (dec.op == brsse_pkg::literal_minus_accumulator_op) begin
        operand <= dec.faddr; // RULE_07
      end else begin
        operand <= file_rd_data;
      end
    end
  end

  // ==========================================================================
  // Process phase: arithmetic and flags
  always_comb begin
    diff        = {1'b0, operand} + {1'b0, ~accum} + 9'h001;
    diff_low    = {1'b0, operand[3:0]} + {1'b0, ~accum[3:0]} + 5'h01;
    next_result = operand;
    next_flags  = status;
    case (dec.op)
      brsse_pkg::rotate_right_no_carry_op: begin
        next_result                  = {operand[0], operand[7:1]}; // RULE_01
        next_flags[brsse_pkg::FLAG_N] = next_result[7]; // RULE_01
        next_flags[brsse_pkg::FLAG_Z] = (next_result == 8'h00); // RULE_01
      end
      brsse_pkg::set_all_ones_op: begin
        next_result = brsse_pkg::ALL_ONES; // RULE_06
      end
      brsse_pkg::literal_minus_accumulator_op,
      brsse_pkg::register_minus_accumulator_op: begin
        next_result                    = diff[7:0]; // RULE_07 RULE_09
        next_flags[brsse_pkg::FLAG_C]  = diff[8]; // RULE_08
        next_flags[brsse_pkg::FLAG_Z]  = (diff[7:0] == 8'h00); // RULE_08
        next_flags[brsse_pkg::FLAG_N]  = diff[7]; // RULE_07 RULE_09
        next_flags[brsse_pkg::FLAG_HALF_CARRY]   = diff_low[4]; // RULE_10
        next_flags[brsse_pkg::FLAG_SIGNED_RANGE] = (operand[7] != accum[7]) &&
                                                   (diff[7] != operand[7]); // RULE_10
      end
      default: begin
        next_result = operand;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      flags  <= brsse_pkg::RST_STATUS;
    end else if (state == brsse_pkg::st_process) begin
      result <= next_result;
      flags  <= next_flags;
    end
  end

  // ==========================================================================
  // Write phase: destination routing
  always_comb begin
    file_wr = '0;
    if ((state == brsse_pkg::st_write) && dec.dest_file) begin
      file_wr.en   = 1'b1; // RULE_02
      file_wr.addr = eff_addr;
      file_wr.data = result;
    end else if (wr_done && (paddr == brsse_pkg::OFS_MEM_DATA)) begin
      file_wr.en   = 1'b1;
      file_wr.addr = mem_addr;
      file_wr.data = pwdata[7:0];
    end
  end

  assign file_rd_addr = (state == brsse_pkg::st_idle) ? mem_addr : eff_addr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum <= brsse_pkg::RST_ACCUM;
    end else if ((state == brsse_pkg::st_write) && !dec.dest_file) begin
      accum <= result; // RULE_02
    end else if (wr_done && (paddr == brsse_pkg::OFS_ACCUM)) begin
      accum <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= brsse_pkg::RST_STATUS;
    end else if (state == brsse_pkg::st_write) begin
      status <= flags; // RULE_08
    end else if (wr_done && (paddr == brsse_pkg::OFS_STATUS)) begin
      status <= pwdata[brsse_pkg::STATUS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_instr  <= brsse_pkg::RST_INSTR;
      last_result <= 8'h00;
      last_addr   <= '0;
    end else if (state == brsse_pkg::st_write) begin
      last_instr  <= work_word;
      last_result <= result;
      last_addr   <= eff_addr;
    end
  end

  // ==========================================================================
  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_enable           <= brsse_pkg::RST_CTRL;
      bank_select_register <= brsse_pkg::RST_BANK;
      index_base           <= brsse_pkg::RST_INDEX;
      mem_addr             <= brsse_pkg::RST_MEM_ADDR;
    end else if (wr_done) begin
      if (paddr == brsse_pkg::OFS_CTRL) begin
        ext_enable <= pwdata[brsse_pkg::CTRL_EXT_BIT];
      end else if (paddr == brsse_pkg::OFS_BANK) begin
        bank_select_register <= pwdata[3:0];
      end else if (paddr == brsse_pkg::OFS_INDEX) begin
        index_base <= pwdata[brsse_pkg::DATA_ADDR_W-1:0];
      end else if (paddr == brsse_pkg::OFS_MEM_ADDR) begin
        mem_addr <= pwdata[brsse_pkg::DATA_ADDR_W-1:0];
      end
    end
  end

  // ==========================================================================
  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (setup && !(instr_hit && instr_ok)) begin
      pready <= 1'b1;
    end else if (state == brsse_pkg::st_write) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !addr_known(paddr) || (instr_hit && !instr_ok);
    end else if (psel && penable && pready) begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (paddr == brsse_pkg::OFS_CTRL) begin
        prdata <= {31'h0000_0000, ext_enable};
      end else if (paddr == brsse_pkg::OFS_ACCUM) begin
        prdata <= {24'h00_0000, accum};
      end else if (paddr == brsse_pkg::OFS_STATUS) begin
        prdata <= {27'h000_0000, status};
      end else if (paddr == brsse_pkg::OFS_BANK) begin
        prdata <= {28'h000_0000, bank_select_register};
      end else if (paddr == brsse_pkg::OFS_INDEX) begin
        prdata <= {20'h0_0000, index_base};
      end else if (paddr == brsse_pkg::OFS_INSTR) begin
        prdata <= {16'h0000, last_instr};
      end else if (paddr == brsse_pkg::OFS_MEM_ADDR) begin
        prdata <= {20'h0_0000, mem_addr};
      end else if (paddr == brsse_pkg::OFS_MEM_DATA) begin
        prdata <= {24'h00_0000, file_rd_data};
      end else if (paddr == brsse_pkg::OFS_INFO) begin
        prdata <= {12'h000, last_result, last_addr};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else if (setup) begin
      prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Data memory
  brsse_general_purpose_file #(
    .DEPTH_W (FILE_DEPTH_W)
  ) u_file (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (file_wr),
    .rd_addr (file_rd_addr),
    .rd_data (file_rd_data)
  );

endmodule : brsse_exec
`default_nettype wire

// >>> rtl/brsse_general_purpose_file.sv
`timescale 1ns/1ps
`default_nettype none
module brsse_general_purpose_file #(
  parameter int DEPTH_W = 12
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire brsse_pkg::brsse_wr_t                 wr,
  input  wire logic [brsse_pkg::DATA_ADDR_W-1:0]    rd_addr,
  output logic      [7:0]                           rd_data
);

  logic [7:0] mem [2**DEPTH_W];

  // ==========================================================================
  // Storage cells
  for (genvar i = 0; i < 2**DEPTH_W; i++) begin : g_cell
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= brsse_pkg::RST_FILE;
      end else if (wr.en && (wr.addr[DEPTH_W-1:0] == DEPTH_W'(i))) begin
        mem[i] <= wr.data;
      end
    end
  end

  // Upper address bits wrap when the file is smaller than the space
  assign rd_data = mem[rd_addr[DEPTH_W-1:0]];

endmodule : brsse_general_purpose_file
`default_nettype wire

// >>> tb/brsse_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module brsse_core_model (
  input  wire logic                              pclk,
  output logic                                   psel,
  output logic                                   penable,
  output logic                                   pwrite,
  output logic [brsse_pkg::APB_ADDR_W-1:0]       paddr,
  output logic [31:0]                            pwdata,
  input  wire logic [31:0]                       prdata,
  input  wire logic                              pready,
  input  wire logic                              pslverr
);
  initial begin
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // One whole transfer; lines show inverted values once released
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] v,
                      output logic [31:0] rd_v, output logic err);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd_v = prdata;
    err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    paddr   <= ~a;
    pwdata  <= ~v;
  endtask : xfer
endmodule : brsse_core_model
`default_nettype wire

// >>> tb/brsse_exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
module brsse_exec_sva #(
  parameter int FILE_DEPTH_W = 12
) (
  input wire logic                               pclk,
  input wire logic                               presetn,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [brsse_pkg::APB_ADDR_W-1:0]   paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  input wire logic                               pready,
  input wire logic                               pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup;
  logic instr_wr;
  logic valid_op;
  logic done;
  logic last_set;

  assign setup    = psel && !penable;
  assign instr_wr = pwrite && (paddr == brsse_pkg::OFS_INSTR);
  assign done     = psel && penable && pready;
  assign valid_op = (pwdata[15:10] == brsse_pkg::OPC_ROTATE) ||
                    (pwdata[15:9] == brsse_pkg::OPC_SET) ||
                    (pwdata[15:8] == brsse_pkg::OPC_SUB_LIT) ||
                    (pwdata[15:10] == brsse_pkg::OPC_SUB_FILE);

  // Remembers whether the last executed word was a set-all-ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_set <= 1'h0;
    end else if (done && instr_wr && !pslverr) begin
      last_set <= (pwdata[15:9] == brsse_pkg::OPC_SET);
    end
  end

  // ==========================================================================
  // Assertions
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_exec_waits;
    setup && instr_wr && valid_op |=> !pready [*4] ##1 (pready && !pslverr);
  endproperty
  a_exec_waits: assert property (p_exec_waits) else $error("execution not four phases");
  property p_bad_op_refused;
    setup && instr_wr && !valid_op |=> pready && pslverr;
  endproperty
  a_bad_op_refused: assert property (p_bad_op_refused) else $error("unknown word accepted");
  property p_plain_zero_wait;
    setup && !instr_wr |=> pready;
  endproperty
  a_plain_zero_wait: assert property (p_plain_zero_wait) else $error("plain access waited");
  property p_set_result;
    done && !pwrite && (paddr == brsse_pkg::OFS_INFO) && last_set
      |-> prdata[19:12] == brsse_pkg::ALL_ONES;
  endproperty
  a_set_result: assert property (p_set_result) else $error("set result not all ones");
  property p_status_width;
    done && !pwrite && (paddr == brsse_pkg::OFS_STATUS) |-> prdata[31:5] == 27'h0;
  endproperty
  a_status_width: assert property (p_status_width) else $error("status upper bits set");

  c_exec: cover property (setup && instr_wr && valid_op);
  c_refused: cover property (done && pslverr);
  c_set_info: cover property (done && !pwrite && (paddr == brsse_pkg::OFS_INFO) && last_set);
endmodule : brsse_exec_sva
`default_nettype wire

// >>> tb/brsse_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module brsse_exec_tb;
  typedef struct packed {
    logic ext; logic [3:0] bank; logic [11:0] idx; logic [7:0] acc; logic [11:0] ea;
    logic [7:0] fv; logic [4:0] st; logic [15:0] ins; logic [7:0] eacc; logic [7:0] efv;
    logic [4:0] est;
  } brsse_row_t;
  // ext bank index accum addr file status word | accum file status
  localparam brsse_row_t ROWS [16] = '{
    '{1'h0, 4'h0, 12'h000, 8'h55, 12'h020, 8'hd7, 5'h0f, 16'h4220, 8'h55, 8'heb, 5'h1b},
    '{1'h0, 4'h0, 12'h000, 8'h55, 12'h020, 8'hd7, 5'h00, 16'h4020, 8'heb, 8'hd7, 5'h10},
    '{1'h0, 4'h3, 12'h000, 8'h55, 12'h345, 8'h01, 5'h04, 16'h4345, 8'h55, 8'h80, 5'h10},
    '{1'h0, 4'h0, 12'h000, 8'h55, 12'hfa0, 8'h00, 5'h10, 16'h42a0, 8'h55, 8'h00, 5'h04},
    '{1'h1, 4'h0, 12'h200, 8'h55, 12'h210, 8'h5a, 5'h1f, 16'h6810, 8'h55, 8'hff, 5'h1f},
    '{1'h1, 4'h0, 12'h200, 8'h55, 12'hf60, 8'h5a, 5'h00, 16'h6860, 8'h55, 8'hff, 5'h00},
    '{1'h0, 4'h5, 12'h000, 8'h55, 12'h533, 8'h5a, 5'h0a, 16'h6933, 8'h55, 8'hff, 5'h0a},
    '{1'h0, 4'h0, 12'h000, 8'h01, 12'h020, 8'h00, 5'h00, 16'h0802, 8'h01, 8'h00, 5'h03},
    '{1'h0, 4'h0, 12'h000, 8'h02, 12'h020, 8'h00, 5'h00, 16'h0802, 8'h00, 8'h00, 5'h07},
    '{1'h0, 4'h0, 12'h000, 8'h03, 12'h020, 8'h00, 5'h00, 16'h0802, 8'hff, 8'h00, 5'h10},
    '{1'h0, 4'h0, 12'h000, 8'h01, 12'h020, 8'h00, 5'h00, 16'h0880, 8'h7f, 8'h00, 5'h09},
    '{1'h0, 4'h0, 12'h000, 8'h02, 12'h020, 8'h03, 5'h00, 16'h5e20, 8'h02, 8'h01, 5'h03},
    '{1'h0, 4'h0, 12'h000, 8'h02, 12'h020, 8'h02, 5'h00, 16'h5c20, 8'h00, 8'h02, 5'h07},
    '{1'h0, 4'h0, 12'h000, 8'h02, 12'h020, 8'h01, 5'h00, 16'h5e20, 8'h02, 8'hff, 5'h10},
    '{1'h0, 4'h7, 12'h000, 8'hff, 12'h710, 8'h7f, 5'h00, 16'h5f10, 8'hff, 8'h80, 5'h1a},
    '{1'h1, 4'h2, 12'h200, 8'h55, 12'h2c0, 8'h08, 5'h00, 16'h43c0, 8'h55, 8'h04, 5'h00}};
  localparam logic [11:0] RST_OFS [9] = '{brsse_pkg::OFS_CTRL, brsse_pkg::OFS_ACCUM,
    brsse_pkg::OFS_STATUS, brsse_pkg::OFS_BANK, brsse_pkg::OFS_INDEX, brsse_pkg::OFS_INSTR,
    brsse_pkg::OFS_MEM_ADDR, brsse_pkg::OFS_MEM_DATA, brsse_pkg::OFS_INFO};
  localparam logic [31:0] RST_EXP [9] = '{{31'h0, brsse_pkg::RST_CTRL},
    {24'h0, brsse_pkg::RST_ACCUM}, {27'h0, brsse_pkg::RST_STATUS}, {28'h0, brsse_pkg::RST_BANK},
    {20'h0, brsse_pkg::RST_INDEX}, {16'h0, brsse_pkg::RST_INSTR},
    {20'h0, brsse_pkg::RST_MEM_ADDR}, {24'h0, brsse_pkg::RST_FILE}, 32'h0};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] d;
  logic        e;
  brsse_row_t  r;
  int          n_errors;
  int          total_checks;

  brsse_exec #(.FILE_DEPTH_W(12)) brsse_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  brsse_core_model brsse_core_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] rd_v;
    logic        err;
    brsse_core_model_i.xfer(1'h1, a, v, rd_v, err);
    chk({31'h0, err}, 32'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic err;
    brsse_core_model_i.xfer(1'h0, a, 32'h0, v, err);
    chk({31'h0, err}, 32'h0);
  endtask : rd

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    presetn = 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    // ========================================================================
    // Table of instructions
    for (int i = 0; i < 16; i++) begin
      r = ROWS[i];
      wr(brsse_pkg::OFS_CTRL, {31'h0, r.ext});
      wr(brsse_pkg::OFS_BANK, {28'h0, r.bank});
      wr(brsse_pkg::OFS_INDEX, {20'h0, r.idx});
      wr(brsse_pkg::OFS_ACCUM, {24'h0, r.acc});
      wr(brsse_pkg::OFS_STATUS, {27'h0, r.st});
      wr(brsse_pkg::OFS_MEM_ADDR, {20'h0, r.ea});
      wr(brsse_pkg::OFS_MEM_DATA, {24'h0, r.fv});
      brsse_core_model_i.xfer(1'h1, brsse_pkg::OFS_INSTR, {16'h0, r.ins}, d, e);
      chk({31'h0, e}, 32'h0);
      rd(brsse_pkg::OFS_ACCUM, d);
      chk(d, {24'h0, r.eacc});
      rd(brsse_pkg::OFS_MEM_DATA, d);
      chk(d, {24'h0, r.efv});
      rd(brsse_pkg::OFS_STATUS, d);
      chk(d, {27'h0, r.est});
      if (r.ins[15:8] != brsse_pkg::OPC_SUB_LIT) begin
        rd(brsse_pkg::OFS_INFO, d);
        chk({20'h0, d[11:0]}, {20'h0, r.ea});
      end
    end
    // ========================================================================
    // Refusals
    for (int i = 0; i < 2; i++) begin
      brsse_core_model_i.xfer(1'h0, (i == 0) ? 12'h024 : 12'h006, 32'h0, d, e);
      chk({d[30:0], e}, 32'h1);
    end
    wr(brsse_pkg::OFS_ACCUM, 32'h33);
    for (int i = 0; i < 2; i++) begin
      brsse_core_model_i.xfer(1'h1, brsse_pkg::OFS_INSTR, (i == 0) ? 32'hffff : 32'h0900, d, e);
      chk({31'h0, e}, 32'h1);
    end
    rd(brsse_pkg::OFS_ACCUM, d);
    chk(d, 32'h33);
    rd(brsse_pkg::OFS_INSTR, d);
    chk(d, {16'h0, ROWS[15].ins});
    wr(brsse_pkg::OFS_INFO, 32'hffffffff);
    rd(brsse_pkg::OFS_INFO, d);
    chk({20'h0, d[11:0]}, {20'h0, ROWS[15].ea});
    // ========================================================================
    // Second reset mid-run
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      rd(RST_OFS[i], d);
      chk(d, RST_EXP[i]);
    end
    conclude();
  end
endmodule : brsse_exec_tb

bind brsse_exec brsse_exec_sva #(.FILE_DEPTH_W(FILE_DEPTH_W)) brsse_exec_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
